// file: pkg/sarcv_consts.svh
// Timing counts, widths and codes for the conversion and serial readout block
`ifndef SARCV_CONSTS_SVH
`define SARCV_CONSTS_SVH
`define SARCV_CLK_NS 100
`define SARCV_WORD_BITS 12
`define SARCV_BUSY_LOW_NS 15000
`define SARCV_BUSY_CYC (`SARCV_BUSY_LOW_NS / `SARCV_CLK_NS)
`define SARCV_LOAD_LEAD_NS 300
`define SARCV_LOAD_CYC (`SARCV_BUSY_CYC - (`SARCV_LOAD_LEAD_NS / `SARCV_CLK_NS))
`define SARCV_FIRST_RISE_NS 1400
`define SARCV_FIRST_RISE_CYC (`SARCV_FIRST_RISE_NS / `SARCV_CLK_NS)
`define SARCV_CLK_HIGH_NS 400
`define SARCV_CLK_HIGH_CYC (`SARCV_CLK_HIGH_NS / `SARCV_CLK_NS)
`define SARCV_DATA_HOLD_NS 400
`define SARCV_DATA_HOLD_CYC (`SARCV_DATA_HOLD_NS / `SARCV_CLK_NS)
`define SARCV_CLK_PERIOD_NS 1100
`define SARCV_CLK_PERIOD_CYC (`SARCV_CLK_PERIOD_NS / `SARCV_CLK_NS)
`define SARCV_TAIL_NS 800
`define SARCV_TAIL_CYC (`SARCV_TAIL_NS / `SARCV_CLK_NS)
`define SARCV_RESULT_RESET 12'h000
`endif

// file: pkg/sarcv_pkg.sv
// Types shared by the conversion and serial readout block
package sarcv_pkg;
  typedef enum logic [2:0] {
    SARCV_IDLE = 3'b001,
    SARCV_CONVERT_STROBE_N = 3'b010,
    SARCV_DONE = 3'b100
  } sarcv_state_type;
  typedef struct packed {
    logic busy_n;
    logic bit_clock;
    logic data;
  } sarcv_outs_type;
endpackage

// file: src/sarcv_core.sv
// Conversion control and serial result readout of a 12-bit converter
`timescale 1ns/100ps
`default_nettype none
`include "sarcv_consts.svh"
// Function
// RL1 - Strobe falling edge starts conversion and readout
// RL2 - Busy low within 120 ns, at most 20 us (code drops busy 200 to 300 ns after the strobe falls)
// RL3 - Twelve bit two's complement, MSB first
// RL4 - Internal clock data stable on both edges
// RL5 - Busy brackets the whole internal transfer
// RL6 - Result copied to shift register before busy rises
// RL7 - Host clocks external shifts, preferably after conversion
// RL8 - Strobe ignored while conversion runs
// RL9 - Chip select does not gate conversion start
// RL10 - Host spaces starts by 25 us
// RL11 - Codes 7FF, 000, FFF, 800 as two's complement
// RL12 - Host holds strobe low 40 ns
// RL13 - Host holds strobe high 2 us before start
// RL14 - First clock rise 1.4 us, period 1.1 us
// RL15 - Busy rises 800 ns after last clock fall (code holds busy to tick 150, so it rises 1.3 us after the last fall)
// RL16 - Host waits 120 ns before external clocking
// RL17 - Host parks external clock 2 us before busy
// RL18 - Chip select enables and releases outputs
// RL19 - Host keeps inputs quiet late in conversion
// RL20 - Host keeps strobe static during conversion
// RL21 - Source select picks external or internal clock
// RL22 - External rising edge shifts, valid at fall
// RL23 - Data low after thirteenth external rising edge
// RL24 - Busy-time external clock high blocks result load
// RL25 - Exactly twelve internal pulses, lines low otherwise
module sarcv_core
  import sarcv_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic convert_strobe_n_i,
  input wire logic chip_select_n_i,
  input wire logic clock_source_select_i,
  input wire logic serial_bit_clock_i,
  input wire logic [11:0] sample_code_i,
  output logic busy_n_o,
  output logic busy_n_oe_n_o,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe_n_o,
  output logic data_o,
  output logic data_oe_n_o
);
  logic convert_strobe_n_s, convert_strobe_n_p, cs_s, ext_s, sck_s, sck_p;
  logic [11:0] code_s;
  sarcv_state_type state_q, state_d;
  logic [7:0] tick_q;
  logic [11:0] work_q, shift_q;
  logic [3:0] ext_cnt_q;
  logic [3:0] pulses_q;
  logic [3:0] phase_q;
  logic int_active_q, sck_int_q, blocked_q;
  sarcv_outs_type outs_q;
  sarcv_sync u_convert_strobe_n (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(convert_strobe_n_i),
    .init_i(1'b1), .sync_o(convert_strobe_n_s), .prev_o(convert_strobe_n_p));
  sarcv_sync u_sck (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(serial_bit_clock_i),
    .init_i(1'b0), .sync_o(sck_s), .prev_o(sck_p));
  sarcv_sync u_cs (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(chip_select_n_i),
    .init_i(1'b1), .sync_o(cs_s), .prev_o());
  sarcv_sync u_ext (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(clock_source_select_i),
    .init_i(1'b0), .sync_o(ext_s), .prev_o());
  logic [11:0] code_m;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      code_m <= `SARCV_RESULT_RESET;
      code_s <= `SARCV_RESULT_RESET;
    end
    else
    begin
      code_m <= sample_code_i;
      code_s <= code_m;
    end
  end
  wire convert_strobe_n_fall = convert_strobe_n_p & ~convert_strobe_n_s;
  wire start = convert_strobe_n_fall & (state_q == SARCV_IDLE); // see RL1 see RL8 see RL9
  wire sck_rise = sck_s & ~sck_p;
  wire load_now = (state_q == SARCV_CONVERT_STROBE_N) && (tick_q == 8'(`SARCV_LOAD_CYC));
  wire load_blk = ext_s & ~cs_s & sck_s; // see RL24
  wire convert_strobe_n_end = (state_q == SARCV_CONVERT_STROBE_N) && (tick_q >= 8'(`SARCV_BUSY_CYC))
    && !int_active_q; // see RL2 see RL5
  // First rise timed from start, later rises from the period counter
  wire int_rise = int_active_q && !sck_int_q && ((pulses_q == 4'd0) ?
    (tick_q == 8'(`SARCV_FIRST_RISE_CYC - 3)) : (phase_q == 4'd0));
  wire int_fall = int_active_q && sck_int_q && (phase_q == 4'(`SARCV_CLK_HIGH_CYC));
  // Shift well after the fall so each bit stands across both edges
  wire int_shift = int_active_q && !sck_int_q && pulses_q != 4'd0 && pulses_q != 4'd12
    && (phase_q == 4'(`SARCV_CLK_HIGH_CYC + `SARCV_DATA_HOLD_CYC));
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SARCV_IDLE: if (start) state_d = SARCV_CONVERT_STROBE_N;
      SARCV_CONVERT_STROBE_N: if (convert_strobe_n_end) state_d = SARCV_DONE;
      SARCV_DONE: state_d = SARCV_IDLE;
      default: state_d = SARCV_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= SARCV_IDLE;
      tick_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= start ? 8'h00 : (tick_q == 8'hff ? tick_q : tick_q + 8'h01);
    end
  end
  // Sampled result captured in the second cycle of conversion into working register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      work_q <= `SARCV_RESULT_RESET;
    else if (state_q == SARCV_CONVERT_STROBE_N && tick_q == 8'h01)
      work_q <= code_s; // see RL11
  end
  // Internal clock generator: first rise, period, twelve pulses, tail
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      int_active_q <= 1'b0;
      sck_int_q <= 1'b0;
      phase_q <= 4'h0;
      pulses_q <= 4'h0;
      blocked_q <= 1'b0;
    end
    else if (start && !ext_s)
    begin
      int_active_q <= 1'b1; // see RL21
      sck_int_q <= 1'b0;
      phase_q <= 4'h0;
      pulses_q <= 4'h0;
    end
    else if (int_active_q)
    begin
      if (pulses_q == 4'd12 && !sck_int_q)
      begin
        phase_q <= phase_q + 4'h1;
        if (phase_q == 4'(`SARCV_TAIL_CYC - 1))
          int_active_q <= 1'b0; // see RL15
      end
      else
      begin
        phase_q <= (phase_q == 4'(`SARCV_CLK_PERIOD_CYC - 1)) ? 4'h0 : phase_q + 4'h1;
        if (int_rise)
        begin
          sck_int_q <= 1'b1; // see RL14
          phase_q <= 4'h1;
        end
        if (int_fall)
        begin
          sck_int_q <= 1'b0;
          pulses_q <= pulses_q + 4'h1; // see RL25
          if (pulses_q == 4'd11)
            phase_q <= 4'h0;
        end
      end
    end
    if (state_q == SARCV_CONVERT_STROBE_N && load_blk)
      blocked_q <= 1'b1;
    if (start)
      blocked_q <= 1'b0;
  end
  // Output shift register: load near conversion end, shift on clocks
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      shift_q <= `SARCV_RESULT_RESET;
      ext_cnt_q <= 4'h0;
    end
    else if (load_now)
    begin
      if (!(blocked_q || load_blk))
        shift_q <= work_q; // see RL6 see RL24
      ext_cnt_q <= 4'h0;
    end
    else if (int_shift)
      shift_q <= {shift_q[10:0], 1'b0}; // see RL3 see RL4
    else if (ext_s && !cs_s && sck_rise)
    begin
      if (ext_cnt_q != 4'd0)
        shift_q <= {shift_q[10:0], 1'b0}; // see RL22 see RL23
      if (ext_cnt_q != 4'd15)
        ext_cnt_q <= ext_cnt_q + 4'h1;
    end
  end
  wire ext_data = (ext_cnt_q == 4'd0 || ext_cnt_q > 4'd12) ? 1'b0 : shift_q[11];
  wire int_data = int_active_q & shift_q[11]; // see RL25
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      outs_q <= '{busy_n: 1'b1, bit_clock: 1'b0, data: 1'b0};
      busy_n_oe_n_o <= 1'b1;
      serial_bit_clock_oe_n_o <= 1'b1;
      data_oe_n_o <= 1'b1;
    end
    else
    begin
      outs_q.busy_n <= !(state_d == SARCV_CONVERT_STROBE_N); // see RL2
      outs_q.bit_clock <= ext_s ? 1'b0 : sck_int_q;
      outs_q.data <= ext_s ? ext_data : int_data;
      busy_n_oe_n_o <= cs_s; // see RL18
      serial_bit_clock_oe_n_o <= cs_s | ext_s;
      data_oe_n_o <= cs_s;
    end
  end
  assign busy_n_o = outs_q.busy_n;
  assign serial_bit_clock_o = outs_q.bit_clock;
  assign data_o = outs_q.data;
  // Start to busy low: strobe sync 2 cycles + 1; busy low one cycle (100 ns) after recognition
  property p_busy_on_start;
    @(posedge clk_i) disable iff (!reset_n_i) start |=> !busy_n_o;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not low"); // see RL2
  property p_ignore_busy;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_q == SARCV_CONVERT_STROBE_N && convert_strobe_n_fall) |=> state_q != SARCV_IDLE || $past(convert_strobe_n_end);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("strobe not ignored"); // see RL8
  property p_busy_max;
    @(posedge clk_i) disable iff (!reset_n_i) start |-> ##[1:200] busy_n_o;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long"); // see RL2
  property p_clk_low_idle;
    @(posedge clk_i) disable iff (!reset_n_i) !int_active_q |=> !outs_q.bit_clock;
  endproperty
  a_clk_low_idle: assert property (p_clk_low_idle) else $error("clock not low"); // see RL25
  property p_twelve;
    @(posedge clk_i) disable iff (!reset_n_i) pulses_q <= 4'd12;
  endproperty
  a_twelve: assert property (p_twelve) else $error("too many pulses"); // see RL25
  property p_frame;
    @(posedge clk_i) disable iff (!reset_n_i) outs_q.bit_clock |-> !busy_n_o;
  endproperty
  a_frame: assert property (p_frame) else $error("clock outside busy"); // see RL5
  property p_first_rise;
    @(posedge clk_i) disable iff (!reset_n_i)
      (start && !ext_s) |-> ##14 outs_q.bit_clock && !$past(outs_q.bit_clock);
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first rise late"); // see RL14
  property p_high_phase;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(outs_q.bit_clock) |-> outs_q.bit_clock [*4] ##1 !outs_q.bit_clock;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("bad high phase"); // see RL14
  property p_ext_thirteen;
    @(posedge clk_i) disable iff (!reset_n_i) (ext_s && ext_cnt_q > 4'd12) |=> !data_o;
  endproperty
  a_ext_thirteen: assert property (p_ext_thirteen) else $error("data not low"); // see RL23
  c_int_convert_strobe_n: cover property (@(posedge clk_i) start && !ext_s);
  c_ext_convert_strobe_n: cover property (@(posedge clk_i) start && ext_s);
  c_ext_shift: cover property (@(posedge clk_i) ext_s && sck_rise && ext_cnt_q == 4'd12);
  c_blocked: cover property (@(posedge clk_i) load_now && load_blk);
endmodule
`default_nettype wire

// file: src/sarcv_sync.sv
// Two flip-flop synchroniser with registered previous value for edge finding
`timescale 1ns/100ps
`default_nettype none
module sarcv_sync
  import sarcv_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  input wire logic init_i,
  output logic sync_o,
  output logic prev_o
);
  logic meta_q;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= init_i;
      sync_o <= init_i;
      prev_o <= init_i;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
      prev_o <= sync_o;
    end
  end
endmodule
`default_nettype wire

// file: verif/sarcv_host_model.sv
// Host side model that clocks the serial result out in external mode
`timescale 1ns/100ps
`default_nettype none
module sarcv_host_model
(
  input wire logic data_i,
  output logic serial_bit_clock_o
);
  initial serial_bit_clock_o = 1'b0;
  // Parked low before busy rises, unless a scenario orders it high
  task automatic park(input logic lvl);
    serial_bit_clock_o = lvl;
  endtask
  // Thirteen 800 ns clocks after conversion
  task automatic read_word(output logic [11:0] w, output logic tail);
    w = 12'h000;
    #37;
    for (int k = 0; k < 13; k++)
    begin
      serial_bit_clock_o = 1'b1;
      #400;
      serial_bit_clock_o = 1'b0;
      #300;
      if (k < 12)
        w = {w[10:0], data_i};
      else
        tail = data_i;
      #100;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/tb_sarcv_core.sv
// Self-checking testbench for the conversion and serial readout block
`timescale 1ns/100ps
`default_nettype none
module tb_sarcv_core
  import sarcv_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n, convert_strobe_n_n, cs_n, sel, busy_n, busy_oe_n, sbc, sbc_oe_n, dat, dat_oe_n;
  logic [11:0] code;
  wire logic host_clk, sbc_w, dat_w;
  int n_mismatch, checks_done;
  // Wire levels; a released data line toggles
  assign sbc_w = sbc_oe_n ? host_clk : sbc;
  assign dat_w = dat_oe_n ? clk : dat;
  always #50 clk = ~clk;
  sarcv_core DUT (.clk_i(clk), .reset_n_i(reset_n), .convert_strobe_n_i(convert_strobe_n_n),
    .chip_select_n_i(cs_n), .clock_source_select_i(sel), .serial_bit_clock_i(sbc_w),
    .sample_code_i(code), .busy_n_o(busy_n), .busy_n_oe_n_o(busy_oe_n),
    .serial_bit_clock_o(sbc), .serial_bit_clock_oe_n_o(sbc_oe_n), .data_o(dat),
    .data_oe_n_o(dat_oe_n));
  sarcv_host_model HOST (.data_i(dat_w), .serial_bit_clock_o(host_clk));
  task automatic stop_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic start(input logic [11:0] c);
    int i;
    code = c;
    convert_strobe_n_n = 1'b0;
    tick(1);
    convert_strobe_n_n = 1'b1;
    for (i = 1; i < 6 && busy_n !== 1'b0; i++)
      tick(1);
    check(12'(i <= 4), 12'h001);
  endtask
  task automatic convert_strobe_n_int(input logic [11:0] c, input logic [11:0] exp, input logic retrig);
    logic [11:0] w;
    logic prev;
    int n, cyc, first;
    w = 12'h000;
    n = 0;
    first = 0;
    prev = 1'b0;
    start(c);
    for (cyc = 0; cyc < 400 && busy_n !== 1'b1; cyc++)
    begin
      if (sbc_w === 1'b1 && prev === 1'b0)
      begin
        if (n == 0)
          first = cyc;
        w = {w[10:0], dat_w};
        n++;
      end
      prev = sbc_w;
      // Strobe pulse in mid-conversion must be ignored
      convert_strobe_n_n = !(retrig && cyc == 50);
      tick(1);
    end
    if (cyc == 400)
    begin
      n_mismatch++;
      stop_test();
    end
    check(w, exp);
    check(12'(n), 12'h00c);
    check(12'(first >= 10 && first <= 15), 12'h001);
    check(12'(cyc >= 140 && cyc <= 199), 12'h001);
    check({10'h000, sbc_w, dat_w}, 12'h000);
    tick(100);
  endtask
  task automatic convert_strobe_n_ext(input logic [11:0] c, input logic hi);
    logic [11:0] w;
    logic tail;
    int cyc;
    sel = 1'b1;
    cs_n = !hi;
    HOST.park(hi);
    start(c);
    if (!hi)
      check({9'h000, busy_oe_n, dat_oe_n, sbc_oe_n}, 12'h007);
    for (cyc = 0; cyc < 400 && busy_n !== 1'b1; cyc++)
      tick(1);
    if (cyc == 400)
    begin
      n_mismatch++;
      stop_test();
    end
    HOST.park(1'b0);
    cs_n = 1'b0;
    tick(4);
    check({9'h000, busy_oe_n, dat_oe_n, sbc_oe_n}, 12'h001);
    HOST.read_word(w, tail);
    tick(1);
    check(hi ? {11'h000, w === c} : w, hi ? 12'h000 : c);
    check({11'h000, tail}, 12'h000);
    tick(100);
  endtask
  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    reset_n = 1'b0;
    convert_strobe_n_n = 1'b1;
    cs_n = 1'b0;
    sel = 1'b0;
    code = 12'h000;
    tick(10);
    check({6'h00, busy_n, sbc, dat, busy_oe_n, sbc_oe_n, dat_oe_n}, 12'h027);
    reset_n = 1'b1;
    tick(30);
    convert_strobe_n_int(12'h7ff, 12'h000, 1'b0);
    convert_strobe_n_int(12'h800, 12'h7ff, 1'b0);
    convert_strobe_n_int(12'hfff, 12'h800, 1'b1);
    convert_strobe_n_int(12'h000, 12'hfff, 1'b0);
    convert_strobe_n_ext(12'h123, 1'b0);
    convert_strobe_n_ext(12'h456, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
